// *** aeis_pie_model.sv ***
// expansion controller model: counts the pulses of each interrupt line
// assumes pulses are one clk cycle wide, eight count bits per line
`timescale 1ns/100ps
module aeis_pie_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // lines in, pulse counts out
    input  wire logic [3:0]  line,
    output logic      [31:0] cnt
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 32'h0000_0000;
        end else begin
            for (int i = 0; i < 4; i++) begin
                cnt[i*8+:8] <= cnt[i*8+:8] + 8'(line[i]);
            end
        end
    end
endmodule

// *** aeis_pkg.sv ***
// types shared by the eoc interrupt select block
// assumes sixteen end-of-conversion sources and four interrupt lines
package aeis_pkg;

    // ****************************************************************
    // event carrier and line configuration
    // ****************************************************************
    typedef struct packed {
        logic [15:0] acq_end;
        logic [15:0] conv_end;
    } aeis_eoc_type;

    typedef struct packed {
        logic       cont;
        logic       enable;
        logic [3:0] sel;
    } aeis_line_cfg_type;

    typedef enum logic {
        AEIS_POS_ACQ_END,
        AEIS_POS_CONV_END
    } aeis_pulse_pos_type;

endpackage

// *** aeis_regs.svh ***
// register indices, field positions and reset values of the eoc interrupt select block
// assumes word-aligned byte addressing: byte address = index * 4
`ifndef AEIS_REGS_SVH
`define AEIS_REGS_SVH

// ****************************************************************
// register indices
// ****************************************************************
`define AEIS_IDX_CTL        6'h00
`define AEIS_IDX_FLAG       6'h03
`define AEIS_IDX_FLAG_CLR   6'h04
`define AEIS_IDX_OVF        6'h05
`define AEIS_IDX_OVF_CLR    6'h06
`define AEIS_IDX_SEL12      6'h07
`define AEIS_IDX_SEL34      6'h08
`define AEIS_IDX_PRICTL     6'h09
`define AEIS_IDX_IRQ_STAT   6'h10
`define AEIS_IDX_IRQ_MASK   6'h11

// ****************************************************************
// field positions
// ****************************************************************
`define AEIS_CTL_PULSE_POS  2
`define AEIS_SEL_LO_MSB     3
`define AEIS_SEL_ENABLE     5
`define AEIS_SEL_CONT       6
`define AEIS_SEL_HI_OFFSET  8
`define AEIS_SEL_MASK       16'h6F6F
`define AEIS_PRI_LSB        0
`define AEIS_PRI_MSB        4
`define AEIS_RRP_LSB        5
`define AEIS_RRP_MSB        9

// ****************************************************************
// reset values
// ****************************************************************
`define AEIS_RST_SEL        16'h0000
`define AEIS_RST_PRICTL     16'h0200
`define AEIS_RST_RRP        5'h10
`define AEIS_RST_PRI        5'h00
`define AEIS_RST_READDATA   32'h0000_0000

`endif

// *** aeis_top.sv ***
// eoc interrupt select: four interrupt lines, each fed by one of sixteen eoc events,
// with flags, overflow and an avalon-mm register slave
// assumes eoc pulses are one cycle wide and come from logic on CORE_CLK
//
// Overview of operation
// - writing one clears flag, zero ignored, reads zero
// - same-cycle clear beats set, raises overflow
// - four-bit field picks eoc source per line
// - enable bit gates pulses of each line
// - non-continuous: no pulse while flag set
// - continuous: pulse on every selected event except one met by a same-cycle clear
// - lines one and two at index 7h
// - lines three and four at index 8h
// - selection fields reset zero, reserved read zero
// - priority control resets 200h, pointer 10h at bits 9:5
// - flag shows pulse since last clear
// - non-continuous: event on set flag raises overflow instead
// - pulse position picks acquisition or conversion end
`timescale 1ns/100ps
`include "aeis_regs.svh"

module aeis_top (
    // clock and reset
    input  wire logic                   CORE_CLK,
    input  wire logic                   RST_N,
    // avalon-mm slave
    input  wire logic [7:0]             AVS_ADDRESS,
    input  wire logic                   AVS_READ,
    input  wire logic                   AVS_WRITE,
    input  wire logic [3:0]             AVS_BYTEENABLE,
    input  wire logic [31:0]            AVS_WRITEDATA,
    output logic      [31:0]            AVS_READDATA,
    output logic                        AVS_WAITREQUEST,
    // end-of-conversion events
    input  wire aeis_pkg::aeis_eoc_type EOC_EVENTS,
    // interrupt lines to the expansion controller
    output logic      [3:0]             INTERRUPT_LINE,
    // arbitration control and system interrupt
    output logic      [4:0]             SOC_PRIORITY,
    output logic                        IRQ
);
    import aeis_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    logic               ack_reg;
    logic [31:0]        readdata_reg;
    logic [31:0]        readdata_next;
    aeis_pulse_pos_type pulse_pos_reg;
    logic [15:0]        sel12_reg;
    logic [15:0]        sel34_reg;
    logic [4:0]         pri_reg;
    logic [4:0]         rrp_reg;
    logic [3:0]         flag_reg;
    logic [3:0]         flag_next;
    logic [3:0]         ovf_reg;
    logic [3:0]         ovf_next;
    logic [3:0]         pulse_reg;
    logic [7:0]         irq_stat_reg;
    logic [7:0]         irq_stat_next;
    logic [7:0]         irq_mask_reg;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    logic [5:0]  idx;
    logic        wr_go;
    logic        rd_go;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic [3:0]  flag_clr;
    logic [3:0]  ovf_clr;
    logic [7:0]  stat_clr;

    assign idx   = AVS_ADDRESS[7:2];
    // a request is answered in its second cycle
    assign wr_go = AVS_WRITE & ack_reg;
    assign rd_go = AVS_READ & ~ack_reg;
    assign wmask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    assign wdata = AVS_WRITEDATA[15:0] & wmask;

    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
    assign AVS_READDATA    = readdata_reg;

    always_comb begin
        flag_clr = 4'h0;
        ovf_clr  = 4'h0;
        stat_clr = 8'h00;
        if (wr_go && idx == `AEIS_IDX_FLAG_CLR) begin
            flag_clr = wdata[3:0];
        end else if (wr_go && idx == `AEIS_IDX_OVF_CLR) begin
            ovf_clr = wdata[3:0];
        end else if (wr_go && idx == `AEIS_IDX_IRQ_STAT) begin
            stat_clr = wdata[7:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (AVS_READ | AVS_WRITE) & ~ack_reg;
        end
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    always_comb begin
        readdata_next = 32'h0000_0000;
        if (idx == `AEIS_IDX_CTL) begin
            readdata_next[`AEIS_CTL_PULSE_POS] = pulse_pos_reg;
        end else if (idx == `AEIS_IDX_FLAG) begin
            readdata_next[3:0] = flag_reg;
        end else if (idx == `AEIS_IDX_OVF) begin
            readdata_next[3:0] = ovf_reg;
        end else if (idx == `AEIS_IDX_SEL12) begin
            readdata_next[15:0] = sel12_reg;
        end else if (idx == `AEIS_IDX_SEL34) begin
            readdata_next[15:0] = sel34_reg;
        end else if (idx == `AEIS_IDX_PRICTL) begin
            readdata_next[`AEIS_RRP_MSB:`AEIS_RRP_LSB] = rrp_reg;
            readdata_next[`AEIS_PRI_MSB:`AEIS_PRI_LSB] = pri_reg;
        end else if (idx == `AEIS_IDX_IRQ_STAT) begin
            readdata_next[7:0] = irq_stat_reg;
        end else if (idx == `AEIS_IDX_IRQ_MASK) begin
            readdata_next[7:0] = irq_mask_reg;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            readdata_reg <= `AEIS_RST_READDATA;
        end else if (rd_go) begin
            readdata_reg <= readdata_next;
        end
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pulse_pos_reg <= AEIS_POS_ACQ_END;
        end else if (wr_go && idx == `AEIS_IDX_CTL && AVS_BYTEENABLE[0]) begin
            pulse_pos_reg <= aeis_pulse_pos_type'(AVS_WRITEDATA[`AEIS_CTL_PULSE_POS]);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sel12_reg <= `AEIS_RST_SEL;
            sel34_reg <= `AEIS_RST_SEL;
        end else if (wr_go && idx == `AEIS_IDX_SEL12) begin
            sel12_reg <= ((sel12_reg & ~wmask) | wdata) & `AEIS_SEL_MASK;
        end else if (wr_go && idx == `AEIS_IDX_SEL34) begin
            sel34_reg <= ((sel34_reg & ~wmask) | wdata) & `AEIS_SEL_MASK;
        end
    end

    // pointer returns to its idle value on any write to the register
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pri_reg <= `AEIS_RST_PRI;
            rrp_reg <= `AEIS_RST_RRP;
        end else if (wr_go && idx == `AEIS_IDX_PRICTL) begin
            if (AVS_BYTEENABLE[0]) begin
                pri_reg <= AVS_WRITEDATA[`AEIS_PRI_MSB:`AEIS_PRI_LSB];
            end
            rrp_reg <= `AEIS_RST_RRP;
        end
    end

    assign SOC_PRIORITY = pri_reg;

    // ****************************************************************
    // line logic
    // ****************************************************************
    function automatic aeis_line_cfg_type line_cfg(input logic [15:0] r, input logic hi);
        logic [7:0] b;
        b = hi ? r[15:8] : r[7:0];
        line_cfg.cont   = b[`AEIS_SEL_CONT];
        line_cfg.enable = b[`AEIS_SEL_ENABLE];
        line_cfg.sel    = b[`AEIS_SEL_LO_MSB:0];
    endfunction

    logic [15:0] eoc_vec;
    logic [3:0]  hit;
    logic [3:0]  fire;
    logic [3:0]  ovf_set;

    // pulse position selects which eoc strobe drives the lines
    assign eoc_vec = (pulse_pos_reg == AEIS_POS_CONV_END) ? EOC_EVENTS.conv_end
                                                          : EOC_EVENTS.acq_end;

    always_comb begin
        aeis_line_cfg_type cfg;
        cfg     = '0;
        hit     = 4'h0;
        fire    = 4'h0;
        ovf_set = 4'h0;
        for (int i = 0; i < 4; i++) begin
            cfg = line_cfg((i < 2) ? sel12_reg : sel34_reg, (i % 2) == 1);
            hit[i] = cfg.enable & eoc_vec[cfg.sel];
            // continuous lines ignore the flag, others wait for its clear
            fire[i] = hit[i] & (cfg.cont | ~flag_reg[i]) & ~flag_clr[i];
            ovf_set[i] = hit[i] & ((~cfg.cont & flag_reg[i]) | flag_clr[i]);
        end
    end

    assign flag_next = (flag_reg & ~flag_clr) | fire;
    assign ovf_next  = (ovf_reg & ~ovf_clr) | ovf_set;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            flag_reg <= 4'h0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ovf_reg <= 4'h0;
        end else begin
            ovf_reg <= ovf_next;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pulse_reg <= 4'h0;
        end else begin
            pulse_reg <= fire;
        end
    end

    assign INTERRUPT_LINE = pulse_reg;

    // ****************************************************************
    // system interrupt: sticky status, mask, level output
    // ****************************************************************
    // a new event in the clearing cycle stays set
    assign irq_stat_next = (irq_stat_reg & ~stat_clr) | {ovf_set, fire};

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_stat_reg <= 8'h00;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_mask_reg <= 8'h00;
        end else if (wr_go && idx == `AEIS_IDX_IRQ_MASK && AVS_BYTEENABLE[0]) begin
            irq_mask_reg <= AVS_WRITEDATA[7:0];
        end
    end

    assign IRQ = |(irq_stat_reg & irq_mask_reg);

endmodule

// *** aeis_top_monitor.sv ***
// port checker of aeis_top
// assumes the bind below attaches it to every aeis_top
`timescale 1ns/100ps
module aeis_top_monitor (
    // clock, reset and bus
    input wire logic                   CORE_CLK,
    input wire logic                   RST_N,
    input wire logic [7:0]             AVS_ADDRESS,
    input wire logic                   AVS_READ,
    input wire logic                   AVS_WRITE,
    input wire logic [3:0]             AVS_BYTEENABLE,
    input wire logic [31:0]            AVS_WRITEDATA,
    input wire logic [31:0]            AVS_READDATA,
    input wire logic                   AVS_WAITREQUEST,
    // events and outputs
    input wire aeis_pkg::aeis_eoc_type EOC_EVENTS,
    input wire logic [3:0]             INTERRUPT_LINE,
    input wire logic [4:0]             SOC_PRIORITY,
    input wire logic                   IRQ
);
    import aeis_pkg::*;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_req; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST; endsequence
    sequence s_rd; AVS_READ && !AVS_WAITREQUEST; endsequence
    property p_one_wait; s_req |=> !AVS_WAITREQUEST; endproperty
    a_one_wait: assert property (p_one_wait) else $error("second wait cycle");
    property p_idle; !(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST; endproperty
    a_idle: assert property (p_idle) else $error("wait without request");
    property p_pulse; INTERRUPT_LINE != 4'h0 |-> $past(EOC_EVENTS) != 32'h0000_0000; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse without event");
    property p_clr; s_rd ##0 AVS_ADDRESS[7:2] == 6'h04
        |-> AVS_READDATA == 32'h0000_0000; endproperty
    a_clr: assert property (p_clr) else $error("clear register not zero");
    property p_flag; s_rd ##0 AVS_ADDRESS[7:2] == 6'h03
        |-> AVS_READDATA[31:4] == 28'h000_0000; endproperty
    a_flag: assert property (p_flag) else $error("flag upper bits set");
    property p_sel; s_rd ##0 AVS_ADDRESS[7:2] inside {6'h07, 6'h08}
        |-> (AVS_READDATA & 32'hFFFF_9090) == 32'h0000_0000; endproperty
    a_sel: assert property (p_sel) else $error("reserved select bits set");
    property p_pri; AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS[7:2] == 6'h09
        |=> SOC_PRIORITY == $past(AVS_WRITEDATA[4:0]); endproperty
    a_pri: assert property (p_pri) else $error("priority not written");
    property p_hold; !(AVS_WRITE && !AVS_WAITREQUEST) |=> $stable(SOC_PRIORITY); endproperty
    a_hold: assert property (p_hold) else $error("priority changed alone");
endmodule
bind aeis_top aeis_top_monitor i_mon (.CORE_CLK, .RST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_BYTEENABLE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .EOC_EVENTS,
    .INTERRUPT_LINE, .SOC_PRIORITY, .IRQ);

// *** tb_aeis_top.sv ***
// self-checking bench of aeis_top with an expansion controller model
// assumes package, header, design, model and monitor compile first
`timescale 1ns/100ps
module tb_aeis_top;
    import aeis_pkg::*;
    logic         clk = 0, rst_n = 0, wr = 0, rd = 0, irq;
    logic [7:0]   adr = 8'h00;
    logic [31:0]  wd = 32'h0000_0000, rdata, cnt, exp_cnt = 32'h0000_0000;
    logic [3:0]   lines;
    logic [4:0]   pri;
    logic         wait_r;
    aeis_eoc_type eoc = '0;
    logic [5:0]   ri [9] = '{6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h10, 6'h3F};
    int           n_fail = 0, cmp_count = 0, seed = 32'h0000_89d1;
    aeis_top i_dut (.CORE_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_r), .EOC_EVENTS(eoc), .INTERRUPT_LINE(lines),
        .SOC_PRIORITY(pri), .IRQ(irq));
    aeis_pie_model i_pie (.clk(clk), .rst_n(rst_n), .line(lines), .cnt(cnt));
    initial forever #2.5 clk = ~clk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // c is put on conv_end during the completing cycle of the transfer
    task automatic bus(input logic w, input logic [5:0] ix, input logic [15:0] d,
                       input logic [3:0] c, output logic [31:0] q);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= {ix, 2'b00};
        wd <= {16'h0000, d};
        @(posedge clk);
        eoc <= aeis_eoc_type'({28'h000_0000, c});
        // no cycle count assumed: only the watchdog ends a hung request
        while (wait_r !== 1'b0) begin
            @(posedge clk);
        end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        eoc <= '0;
    endtask
    task automatic wreg(input logic [5:0] ix, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, ix, d, 4'h0, q);
    endtask
    task automatic rchk(input logic [5:0] ix, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, ix, 16'h0000, 4'h0, q);
        check(q, exp);
    endtask
    task automatic fire(input aeis_eoc_type e, output logic [3:0] l);
        @(posedge clk);
        eoc <= e;
        @(posedge clk);
        eoc <= '0;
        @(posedge clk);
        l = lines;
    endtask
    function automatic logic [3:0] exp_lines(aeis_eoc_type e, logic pos, logic [31:0] c);
        logic [15:0] v;
        v = pos ? e.conv_end : e.acq_end;
        for (int i = 0; i < 4; i++) exp_lines[i] = c[i*8+5] & v[c[i*8+:4]];
    endfunction
    initial begin
        #100000;
        n_fail++;
        conclude();
    end
    initial begin
        logic [31:0]  q, s;
        logic [5:0]   ix;
        logic [3:0]   l, ex;
        aeis_eoc_type e;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ri[i]) rchk(ri[i], ri[i] == 6'h09 ? 32'h0000_0200 : 32'h0000_0000);
        check({26'h000_0000, irq, pri}, 32'h0000_0000);
        $display("reset values done");
        for (int i = 0; i < 6; i++) begin
            q = $random(seed);
            ix = 6'h07 + 6'(i % 3);
            wreg(ix, q[15:0]);
            rchk(ix, ix == 6'h09 ? {21'h00_0010, q[4:0]} : q & 32'h0000_6F6F);
        end
        check(32'(pri), {27'h000_0000, q[4:0]});
        $display("register access done");
        for (int n = 0; n < 16; n++) begin
            q = $random(seed);
            s = {2'b00, q[3], 1'b0, 4'(n + 12), 2'b00, q[2], 1'b0, 4'(n + 8),
                 2'b00, q[1], 1'b0, 4'(n + 4), 2'b00, q[0], 1'b0, 4'(n)};
            wreg(6'h00, {13'h0000, n[0], 2'b00});
            rchk(6'h00, {29'h0000_0000, n[0], 2'b00});
            wreg(6'h07, s[15:0]);
            wreg(6'h08, s[31:16]);
            wreg(6'h04, 16'h000F);
            e = $random(seed);
            ex = exp_lines(e, n[0], s);
            fire(e, l);
            check(32'(l), 32'(ex));
            rchk(6'h03, 32'(ex));
            for (int i = 0; i < 4; i++) exp_cnt[i*8+:8] += 8'(ex[i]);
        end
        check(cnt, exp_cnt);
        $display("source select done");
        e = aeis_eoc_type'(32'h0000_0001);
        wreg(6'h06, 16'h000F);
        wreg(6'h08, 16'h0000);
        wreg(6'h07, 16'h0020);
        wreg(6'h04, 16'h000F);
        fire(e, l);
        check(32'(l), 32'h0000_0001);
        fire(e, l);
        check(32'(l), 32'h0000_0000);
        rchk(6'h05, 32'h0000_0001);
        wreg(6'h07, 16'h0060);
        fire(e, l);
        check(32'(l), 32'h0000_0001);
        $display("overflow and continuous done");
        wreg(6'h06, 16'h000F);
        wreg(6'h10, 16'h00FF);
        wreg(6'h11, 16'h0000);
        bus(1'b1, 6'h04, 16'h0001, 4'h1, q);
        @(posedge clk);
        check({27'h000_0000, irq, lines}, 32'h0000_0000);
        rchk(6'h03, 32'h0000_0000);
        rchk(6'h05, 32'h0000_0001);
        wreg(6'h11, 16'h00FF);
        @(posedge clk);
        check(32'(irq), 32'h0000_0001);
        wreg(6'h10, 16'h00FF);
        @(posedge clk);
        check(32'(irq), 32'h0000_0000);
        $display("collision and interrupt done");
        conclude();
    end
endmodule
